// [src/sirpse_top.v]
// Behaviour
// - While reset is asserted state returns to idle with both control enables set, the rate is 9600 bit/s and the pulse is the fixed 1.627 us one.
// - The transceiver power-down output follows the active-low reset directly, so it is low during reset.
// - The internal oscillator is stopped while reset is asserted and runs again once reset is released.
// - With the mode select low the block carries transmit data to the infrared output and receive data back.
// - In data mode each low bit on the serial transmit input becomes a short pulse on the infrared output.
// - The transmit pulse is either a fixed 1.627 us or 3/16 of the bit period, chosen by configuration.
// - In data mode each received infrared pulse is stretched to a full bit period on the serial output.
// - With the mode select high serial transmit data is taken as a control word for rate and pulse option.
// - A new control word only takes effect when the mode select returns low.
// - All pulse timing derives from a nominal 3.6864 MHz clock, internal or external.
// - The baud generator offers 13 rates from 1200 up to 115200 bit/s.
// - Transmit pulses on the infrared output are active high.
`timescale 1ns/1ps
`include "sirpse_defines.vh"

module sirpse_top #(
   parameter DIV_W = 8
) (
   input  wire        clock,                 // System clock, 200 MHz.
   input  wire        rst_b,                 // Synchronous reset, active low.
   input  wire        osc_ext_sel,           // High selects osc_clock_in.
   input  wire        osc_clock_in,          // External 3.6864 MHz clock.
   input  wire        program_mode_select,   // High enters programming mode.
   input  wire        serial_tx_in,          // Serial transmit data in.
   output reg         serial_rx_out,         // Stretched receive data out.
   output reg         ir_pulse_out,          // Infrared pulse, active high.
   input  wire        ir_pulse_in,           // Infrared pulse, active low.
   output wire        transceiver_power_down, // Low powers transceiver down.
   input  wire        hsel,                  // AHB slave select.
   input  wire [31:0] haddr,                 // AHB address.
   input  wire [1:0]  htrans,                // AHB transfer type.
   input  wire        hwrite,                // AHB write flag.
   input  wire [2:0]  hsize,                 // AHB size, word only.
   input  wire [31:0] hwdata,                // AHB write data.
   input  wire        hready,                // AHB bus ready.
   output wire        hreadyout,             // AHB slave ready.
   output wire        hresp,                 // AHB response, always OKAY.
   output reg  [31:0] hrdata                 // AHB read data.
);

   // ------------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------------
   localparam RX_IDLE = 2'h0;
   localparam RX_START = 2'h1;
   localparam RX_DATA = 2'h2;
   localparam RX_STOP = 2'h3;

   reg  [31:0]      osc_acc_r;
   reg              osc_msb_r;
   reg              ext_clk_r;
   reg              osc_tick;
   reg  [3:0]       rate_r;
   reg              pulse_opt_r;
   reg  [3:0]       pend_rate_r;
   reg              pend_pulse_r;
   reg              pend_valid_r;
   reg              mode_r;
   reg  [DIV_W-1:0] divisor;
   wire             x16_tick;
   reg              tx_prev_r;
   reg  [3:0]       tx_sub_r;
   reg              tx_skip_r;
   reg              tx_bit_act_r;
   reg  [7:0]       tx_pw_r;
   reg              ir_prev_r;
   reg  [3:0]       rx_sub_r;
   reg              rx_str_act_r;
   reg  [1:0]       pr_state_r;
   reg  [3:0]       pr_sub_r;
   reg  [2:0]       pr_bit_r;
   reg  [7:0]       pr_shift_r;
   reg  [31:0]      ctrl_r;
   reg              wr_pend_r;
   reg  [7:0]       wr_addr_r;
   reg  [31:0]      rd_value;
   wire [31:0]      osc_sum;
   wire             addr_phase;
   wire             data_mode;

   // ------------------------------------------------------------------------
   // Reset and oscillator
   // ------------------------------------------------------------------------
   // Power-down follows reset directly with no register delay.
   assign transceiver_power_down = rst_b;

   assign osc_sum = osc_acc_r + `SIRPSE_OSC_STEP;

   // Phase accumulator stands in for the crystal oscillator; it is frozen
   // in reset, and an external clock is edge detected instead when chosen.
   always @(posedge clock) begin
      if (!rst_b) begin
         osc_acc_r <= 32'h00000000;
         osc_msb_r <= 1'b0;
         ext_clk_r <= 1'b0;
         osc_tick  <= 1'b0;
      end else begin
         osc_acc_r <= osc_sum;
         osc_msb_r <= osc_acc_r[31];
         ext_clk_r <= osc_clock_in;
         if (osc_ext_sel) begin
            osc_tick <= osc_clock_in & ~ext_clk_r;
         end else begin
            osc_tick <= osc_acc_r[31] & ~osc_msb_r;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Baud rate selection
   // ------------------------------------------------------------------------
   // Oscillator ticks per 16x tick for each of the thirteen rates.
   always @* begin
      case (rate_r)
         4'h0:    divisor = 8'h02;  // 115200 bit/s.
         4'h1:    divisor = 8'h04;  // 57600 bit/s.
         4'h2:    divisor = 8'h06;  // 38400 bit/s.
         4'h3:    divisor = 8'h08;  // 28800 bit/s.
         4'h4:    divisor = 8'h0C;  // 19200 bit/s.
         4'h5:    divisor = 8'h10;  // 14400 bit/s.
         4'h6:    divisor = 8'h18;  // 9600 bit/s.
         4'h7:    divisor = 8'h20;  // 7200 bit/s.
         4'h8:    divisor = 8'h30;  // 4800 bit/s.
         4'h9:    divisor = 8'h40;  // 3600 bit/s.
         4'hA:    divisor = 8'h60;  // 2400 bit/s.
         4'hB:    divisor = 8'h80;  // 1800 bit/s.
         4'hC:    divisor = 8'hC0;  // 1200 bit/s.
         default: divisor = 8'h18;
      endcase
   end

   sirpse_baud_gen #(
      .DIV_W    (DIV_W)
   ) u_baud (
      .clock    (clock),
      .rst_b    (rst_b),
      .osc_tick (osc_tick),
      .divisor  (divisor),
      .x16_tick (x16_tick)
   );

   // ------------------------------------------------------------------------
   // Mode tracking and control word adoption
   // ------------------------------------------------------------------------
   assign data_mode = ~program_mode_select & ~mode_r;

   // A staged word is adopted on the falling edge of the mode select only.
   always @(posedge clock) begin
      if (!rst_b) begin
         mode_r      <= 1'b0;
         rate_r      <= `SIRPSE_RATE_DEFAULT;
         pulse_opt_r <= `SIRPSE_PULSE_DEFAULT;
      end else begin
         mode_r <= program_mode_select;
         if (mode_r && !program_mode_select && pend_valid_r) begin
            rate_r      <= pend_rate_r;
            pulse_opt_r <= pend_pulse_r;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Transmit pulse shortening
   // ------------------------------------------------------------------------
   // A low bit starts a bit window; each window opens with one short pulse.
   always @(posedge clock) begin
      if (!rst_b) begin
         tx_prev_r    <= 1'b1;
         tx_skip_r    <= 1'b0;
         tx_sub_r     <= 4'h0;
         tx_bit_act_r <= 1'b0;
         tx_pw_r      <= 8'h00;
         ir_pulse_out <= 1'b0;
      end else begin
         tx_prev_r <= serial_tx_in;
         if (!data_mode || !ctrl_r[`SIRPSE_CTRL_TX_EN]) begin
            tx_bit_act_r <= 1'b0;
            tx_pw_r      <= 8'h00;
            ir_pulse_out <= 1'b0;
         end else if (tx_prev_r && !serial_tx_in) begin
            // Falling edge realigns the bit window.
            tx_bit_act_r <= 1'b1;
            tx_skip_r    <= 1'b1;
            tx_sub_r     <= 4'h0;
            tx_pw_r      <= 8'h00;
            ir_pulse_out <= 1'b1;
         end else begin
            if (x16_tick && tx_bit_act_r) begin
               if (tx_sub_r == `SIRPSE_BIT_LAST && tx_skip_r) begin
                  // First window waits one more tick for the edge phase.
                  tx_skip_r <= 1'b0;
               end else if (tx_sub_r == `SIRPSE_BIT_LAST) begin
                  tx_sub_r     <= 4'h0;
                  tx_bit_act_r <= ~serial_tx_in;
                  tx_pw_r      <= 8'h00;
                  ir_pulse_out <= ~serial_tx_in;
               end else begin
                  tx_sub_r <= tx_sub_r + 4'h1;
               end
            end
            // End the pulse after the chosen width.
            if (ir_pulse_out) begin
               if (pulse_opt_r) begin
                  if (x16_tick && tx_sub_r ==
                      `SIRPSE_SIXTEENTH_PULSE - 4'h1) begin
                     ir_pulse_out <= 1'b0;
                  end
               end else if (osc_tick) begin
                  if (tx_pw_r == `SIRPSE_FIXED_PULSE_OSC - 8'h01) begin
                     ir_pulse_out <= 1'b0;
                  end else begin
                     tx_pw_r <= tx_pw_r + 8'h01;
                  end
               end
            end
         end
      end
   end

   // ------------------------------------------------------------------------
   // Receive pulse stretching
   // ------------------------------------------------------------------------
   // The falling edge of an active-low pulse holds the output low for a bit.
   always @(posedge clock) begin
      if (!rst_b) begin
         ir_prev_r     <= 1'b1;
         rx_sub_r      <= 4'h0;
         rx_str_act_r  <= 1'b0;
         serial_rx_out <= 1'b1;
      end else begin
         ir_prev_r <= ir_pulse_in;
         if (!data_mode || !ctrl_r[`SIRPSE_CTRL_RX_EN]) begin
            rx_str_act_r  <= 1'b0;
            serial_rx_out <= 1'b1;
         end else if (ir_prev_r && !ir_pulse_in) begin
            rx_str_act_r  <= 1'b1;
            rx_sub_r      <= 4'h0;
            serial_rx_out <= 1'b0;
         end else if (x16_tick && rx_str_act_r) begin
            if (rx_sub_r == `SIRPSE_BIT_LAST) begin
               rx_str_act_r  <= 1'b0;
               serial_rx_out <= 1'b1;
            end else begin
               rx_sub_r <= rx_sub_r + 4'h1;
            end
         end
      end
   end

   // ------------------------------------------------------------------------
   // Control word receiver
   // ------------------------------------------------------------------------
   // An 8N1 receiver at the current rate runs only in programming mode.
   always @(posedge clock) begin
      if (!rst_b) begin
         pr_state_r   <= RX_IDLE;
         pr_sub_r     <= 4'h0;
         pr_bit_r     <= 3'h0;
         pr_shift_r   <= 8'h00;
         pend_rate_r  <= `SIRPSE_RATE_DEFAULT;
         pend_pulse_r <= `SIRPSE_PULSE_DEFAULT;
         pend_valid_r <= 1'b0;
      end else if (!program_mode_select) begin
         pr_state_r <= RX_IDLE;
         if (mode_r) begin
            pend_valid_r <= 1'b0;
         end
      end else begin
         case (pr_state_r)
            RX_IDLE: begin
               if (!serial_tx_in) begin
                  pr_state_r <= RX_START;
                  pr_sub_r   <= 4'h0;
               end
            end
            RX_START: begin
               if (x16_tick) begin
                  if (pr_sub_r == `SIRPSE_BIT_MID) begin
                     pr_sub_r   <= 4'h0;
                     pr_bit_r   <= 3'h0;
                     pr_state_r <= serial_tx_in ? RX_IDLE : RX_DATA;
                  end else begin
                     pr_sub_r <= pr_sub_r + 4'h1;
                  end
               end
            end
            RX_DATA: begin
               if (x16_tick) begin
                  if (pr_sub_r == `SIRPSE_BIT_LAST) begin
                     pr_sub_r   <= 4'h0;
                     pr_shift_r <= {serial_tx_in, pr_shift_r[7:1]};
                     pr_bit_r   <= pr_bit_r + 3'h1;
                     if (pr_bit_r == 3'h7) begin
                        pr_state_r <= RX_STOP;
                     end
                  end else begin
                     pr_sub_r <= pr_sub_r + 4'h1;
                  end
               end
            end
            RX_STOP: begin
               if (x16_tick) begin
                  if (pr_sub_r == `SIRPSE_BIT_LAST) begin
                     pr_state_r <= RX_IDLE;
                     // Framed words with a valid rate index are staged.
                     if (serial_tx_in && pr_shift_r[`SIRPSE_CW_RATE_MSB:0]
                         < `SIRPSE_RATE_COUNT) begin
                        pend_rate_r  <=
                           pr_shift_r[`SIRPSE_CW_RATE_MSB:0];
                        pend_pulse_r <=
                           pr_shift_r[`SIRPSE_CW_PULSE_BIT];
                        pend_valid_r <= 1'b1;
                     end
                  end else begin
                     pr_sub_r <= pr_sub_r + 4'h1;
                  end
               end
            end
            default: pr_state_r <= RX_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // AHB-Lite register slave
   // ------------------------------------------------------------------------
   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;
   assign addr_phase = hsel & hready & htrans[1];

   // Read value for the address presented in the address phase.
   always @* begin
      rd_value = 32'h00000000;
      case (haddr[7:0])
         `SIRPSE_REG_CTRL:   rd_value = ctrl_r;
         `SIRPSE_REG_STATUS: begin
            rd_value[3:0]                   = rate_r;
            rd_value[`SIRPSE_ST_PULSE]      = pulse_opt_r;
            rd_value[`SIRPSE_ST_PEND_LSB+3:`SIRPSE_ST_PEND_LSB] = pend_rate_r;
            rd_value[`SIRPSE_ST_PEND_PULSE] = pend_pulse_r;
            rd_value[`SIRPSE_ST_PEND_VALID] = pend_valid_r;
            rd_value[`SIRPSE_ST_MODE]       = mode_r;
            rd_value[`SIRPSE_ST_OSC_RUN]    = rst_b;
         end
         default:            rd_value = 32'h00000000;
      endcase
   end

   // Read data is captured in the address phase; writes land in data phase.
   always @(posedge clock) begin
      if (!rst_b) begin
         ctrl_r    <= `SIRPSE_CTRL_RESET;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         hrdata    <= 32'h00000000;
      end else begin
         wr_pend_r <= addr_phase & hwrite;
         wr_addr_r <= haddr[7:0];
         if (addr_phase && !hwrite && haddr[31:8] == 24'h000000) begin
            hrdata <= rd_value;
         end else if (addr_phase) begin
            hrdata <= 32'h00000000;
         end
         if (wr_pend_r && wr_addr_r == `SIRPSE_REG_CTRL) begin
            ctrl_r <= {30'h00000000, hwdata[1:0]};
         end
      end
   end

endmodule // sirpse_top

// [src/sirpse_defines.vh]
`ifndef SIRPSE_DEFINES_VH
`define SIRPSE_DEFINES_VH

// ---------------------------------------------------------------------------
// Clocks and timing
// ---------------------------------------------------------------------------
// System clock 200 MHz, period in ns.
`define SIRPSE_CLK_PERIOD_NS  5
// Nominal pulse oscillator frequency in Hz.
`define SIRPSE_OSC_HZ         3686400
// Internal oscillator phase step, 2^32 * 3.6864 MHz / 200 MHz.
`define SIRPSE_OSC_STEP       32'h04B7F5A5
// Least reset hold time in ns and the clock cycles that it spans.
`define SIRPSE_RESET_HOLD_NS  1000
`define SIRPSE_RESET_HOLD_CYC \
   ((`SIRPSE_RESET_HOLD_NS + `SIRPSE_CLK_PERIOD_NS - 1) / `SIRPSE_CLK_PERIOD_NS)
// Fixed pulse of 1.627 us, counted in oscillator ticks (6 / 3.6864 MHz).
`define SIRPSE_FIXED_PULSE_NS 1627
`define SIRPSE_FIXED_PULSE_OSC 8'h06
// Short pulse of 3/16 bit, in ticks of the 16x baud clock.
`define SIRPSE_SIXTEENTH_PULSE 4'h3
// Oversampling ticks in one bit period, less one.
`define SIRPSE_BIT_LAST       4'hF
// Mid-bit sample point in 16x ticks.
`define SIRPSE_BIT_MID        4'h7

// ---------------------------------------------------------------------------
// Rates and control word
// ---------------------------------------------------------------------------
`define SIRPSE_RATE_COUNT     4'hD
// Rate index 6 is 9600 bit/s, selected by reset.
`define SIRPSE_RATE_DEFAULT   4'h6
// Control word: bits 3:0 rate index, bit 4 pulse option (1 = 3/16 bit).
`define SIRPSE_CW_RATE_MSB    3
`define SIRPSE_CW_PULSE_BIT   4
`define SIRPSE_PULSE_DEFAULT  1'b0

// ---------------------------------------------------------------------------
// Register map
// ---------------------------------------------------------------------------
`define SIRPSE_REG_CTRL       8'h00
`define SIRPSE_REG_STATUS     8'h04
`define SIRPSE_CTRL_RESET     32'h00000003
`define SIRPSE_CTRL_TX_EN     0
`define SIRPSE_CTRL_RX_EN     1
`define SIRPSE_ST_PULSE       4
`define SIRPSE_ST_PEND_LSB    8
`define SIRPSE_ST_PEND_PULSE  12
`define SIRPSE_ST_PEND_VALID  13
`define SIRPSE_ST_MODE        16
`define SIRPSE_ST_OSC_RUN     17

`endif

// [src/sirpse_baud_gen.v]
`timescale 1ns/1ps
`include "sirpse_defines.vh"

// ---------------------------------------------------------------------------
// Baud tick generator
// ---------------------------------------------------------------------------
// Divides the oscillator tick down to a 16x oversampling tick.
module sirpse_baud_gen #(
   parameter DIV_W = 8
) (
   input  wire             clock,     // System clock.
   input  wire             rst_b,     // Synchronous reset, active low.
   input  wire             osc_tick,  // One-cycle oscillator tick.
   input  wire [DIV_W-1:0] divisor,   // Oscillator ticks per 16x tick.
   output reg              x16_tick   // One-cycle 16x baud tick.
);

   reg [DIV_W-1:0] cnt_r;

   // Count oscillator ticks; a new divisor applies at once to the running count.
   always @(posedge clock) begin
      if (!rst_b) begin
         cnt_r    <= {DIV_W{1'b0}};
         x16_tick <= 1'b0;
      end else begin
         x16_tick <= 1'b0;
         if (osc_tick) begin
            if (cnt_r >= divisor - {{(DIV_W-1){1'b0}}, 1'b1}) begin
               cnt_r    <= {DIV_W{1'b0}};
               x16_tick <= 1'b1;
            end else begin
               cnt_r <= cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

endmodule // sirpse_baud_gen

// [verification/sirpse_monitor.sv]
`timescale 1ns/1ps
// ------------------------------------
// Port checker
// ------------------------------------
module sirpse_monitor (
   input logic clock,                  // Clock.
   input logic rst_b,                  // Reset.
   input logic osc_ext_sel,            // Osc source.
   input logic program_mode_select,    // Mode.
   input logic serial_tx_in,           // Serial in.
   input logic serial_rx_out,          // Serial out.
   input logic ir_pulse_out,           // IR out.
   input logic ir_pulse_in,            // IR in.
   input logic transceiver_power_down  // Power down.
);
   logic [17:0] hi_cnt_r;  // Cycles the IR output has stood high.
   logic [17:0] lo_cnt_r;  // Cycles the serial output has stood low.
   // Run lengths of both outputs, for width checks.
   always_ff @(posedge clock) begin
      hi_cnt_r <= (!rst_b || !ir_pulse_out) ? 18'h00000 : hi_cnt_r + 18'h1;
      lo_cnt_r <= (!rst_b || serial_rx_out) ? 18'h00000 : lo_cnt_r + 18'h1;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   property p_pd;
      disable iff (1'b0) transceiver_power_down == rst_b;
   endproperty
   property p_rst_out;
      $rose(rst_b) |-> !ir_pulse_out && serial_rx_out;
   endproperty
   property p_tx_cause;
      $rose(ir_pulse_out) |-> !$past(serial_tx_in) || !$past(serial_tx_in, 2);
   endproperty
   property p_prog_quiet;
      program_mode_select && $past(program_mode_select, 3)
         |-> !$rose(ir_pulse_out);
   endproperty
   property p_pulse_min;
      $fell(ir_pulse_out) |-> hi_cnt_r >= (osc_ext_sel ? 11 : 210);
   endproperty
   property p_pulse_max; hi_cnt_r < 18'd31500; endproperty
   property p_rx_start;
      $fell(ir_pulse_in) && !program_mode_select |-> ##[1:6] !serial_rx_out;
   endproperty
   property p_rx_min;
      $rose(serial_rx_out) |-> lo_cnt_r >= (osc_ext_sel ? 84 : 1600);
   endproperty
   a_pd: assert property (p_pd) else $error("power down not reset");
   a_rst_out: assert property (p_rst_out) else $error("bad reset out");
   a_tx_cause: assert property (p_tx_cause) else $error("stray pulse");
   a_prog_quiet: assert property (p_prog_quiet) else $error("tx in prog");
   a_pulse_min: assert property (p_pulse_min) else $error("short");
   a_pulse_max: assert property (p_pulse_max) else $error("long");
   a_rx_start: assert property (p_rx_start) else $error("no stretch");
   a_rx_min: assert property (p_rx_min) else $error("short bit");
   c_tx: cover property ($rose(ir_pulse_out));
   c_rx: cover property ($fell(serial_rx_out));
   c_mode: cover property ($fell(program_mode_select));
endmodule // sirpse_monitor

bind sirpse_top sirpse_monitor u_mon (
   .clock(clock), .rst_b(rst_b), .osc_ext_sel(osc_ext_sel),
   .program_mode_select(program_mode_select), .serial_tx_in(serial_tx_in),
   .serial_rx_out(serial_rx_out), .ir_pulse_out(ir_pulse_out),
   .ir_pulse_in(ir_pulse_in), .transceiver_power_down(transceiver_power_down)
);

// [verification/sirpse_far_end.sv]
`timescale 1ns/1ps
// ------------------------------------
// Serial port and transceiver model
// ------------------------------------
module sirpse_far_end (
   input  logic clock,         // Clock.
   output logic serial_tx_in,  // UART transmit line.
   output logic ir_pulse_in    // Transceiver receive line.
);
   // Both lines rest high.
   initial begin
      serial_tx_in = 1'b1;
      ir_pulse_in  = 1'b1;
   end
   // Holds the transmit line at v for n cycles; called just after an edge.
   task automatic hold_tx(input logic v, input int n);
      serial_tx_in <= v;
      repeat (n) @(posedge clock);
   endtask
   // Sends one 8N1 byte, least significant bit first.
   task automatic send_byte(input logic [7:0] b, input int bit_cyc);
      hold_tx(1'b0, bit_cyc);
      for (int i = 0; i < 8; i++) begin
         hold_tx(b[i], bit_cyc);
      end
      hold_tx(1'b1, bit_cyc);
   endtask
   // Active-low receive pulse of at least six oscillator ticks.
   task automatic flash(input int n);
      ir_pulse_in <= 1'b0;
      repeat (n) @(posedge clock);
      ir_pulse_in <= 1'b1;
   endtask
endmodule // sirpse_far_end

// [verification/sir_pulse_shaper_endec_test.sv]
`timescale 1ns/1ps
module sir_pulse_shaper_endec_test;
   logic clock, rst_b, osc_ext_sel, osc_clock_in, program_mode_select;
   logic serial_tx_in, serial_rx_out, ir_pulse_out, ir_pulse_in;
   logic transceiver_power_down, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [16:0] seed = 17'd92479;
   int dv[13] = '{2, 4, 6, 8, 12, 16, 24, 32, 48, 64, 96, 128, 192};
   int failures = 0, n_compared = 0;
   int n_pulse = 0, pulse_w = 0, hi_run = 0, n_low = 0, low_w = 0, lo_run = 0;
   sirpse_top u_dut (.clock(clock), .rst_b(rst_b), .osc_ext_sel(osc_ext_sel),
      .osc_clock_in(osc_clock_in), .program_mode_select(program_mode_select),
      .serial_tx_in(serial_tx_in), .serial_rx_out(serial_rx_out),
      .ir_pulse_out(ir_pulse_out), .ir_pulse_in(ir_pulse_in),
      .transceiver_power_down(transceiver_power_down), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata));
   sirpse_far_end u_far (.clock(clock), .serial_tx_in(serial_tx_in),
      .ir_pulse_in(ir_pulse_in));
   // System clock and a 15 ns external oscillator, three cycles a tick.
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   initial begin
      osc_clock_in = 1'b0;
      #1;
      forever #7.5 osc_clock_in = ~osc_clock_in;
   end
   // Counts output pulses and records the width of the latest one.
   always @(posedge clock) begin
      if (ir_pulse_out === 1'b1) hi_run++;
      else if (hi_run > 0) begin
         n_pulse++;
         pulse_w = hi_run;
         hi_run = 0;
      end
      if (serial_rx_out === 1'b0) lo_run++;
      else if (lo_run > 0) begin
         n_low++;
         low_w = lo_run;
         lo_run = 0;
      end
   end
   function automatic logic [16:0] lfsr(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction
   task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input int got, input int lo, input int hi);
      n_compared++;
      if (got < lo || got > hi) begin
         failures++;
         $display("MISMATCH t=%0t %0d not in %0d..%0d", $time, got, lo, hi);
      end
   endtask
   // One single AHB transfer; read data taken at the data-phase edge.
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge clock);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= wr;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      rd = hrdata;
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk_eq(r & m, exp);
   endtask
   // Sends one low bit and one stretched receive pulse, checks widths.
   task automatic bits(input int d, input int lo, input int hi);
      int n0;
      int m0;
      n0 = n_pulse;
      m0 = n_low;
      u_far.hold_tx(1'b0, 48 * d - 8);
      u_far.hold_tx(1'b1, 48 * d);
      chk_rng(n_pulse - n0, 1, 1);
      chk_rng(pulse_w, lo, hi);
      u_far.flash(20);
      repeat (48 * d + 20) @(posedge clock);
      chk_rng(n_low - m0, 1, 1);
      chk_rng(low_w, 45 * d - 2, 48 * d + 4);
   endtask
   // Reset, program a control word, then exercise the link at the rate in force.
   task automatic round(input logic [3:0] idx, input logic opt);
      logic ok;
      logic [3:0] ai;
      int n0;
      ok = idx < 4'hD;
      ai = ok ? idx : 4'h6;
      rst_b <= 1'b0;
      repeat (200) @(posedge clock);
      chk_eq({29'h0, ir_pulse_out, serial_rx_out, transceiver_power_down},
             32'h2);
      rst_b <= 1'b1;
      program_mode_select <= 1'b1;
      repeat (4) @(posedge clock);
      n0 = n_pulse;
      u_far.send_byte({3'h0, opt, idx}, 1152);
      chk_rng(n_pulse - n0, 0, 0);
      rd_chk(32'h4, 32'h1001F, 32'h10006);
      program_mode_select <= 1'b0;
      repeat (4) @(posedge clock);
      rd_chk(32'h4, 32'h1001F, {27'h0, ok & opt, ai});
      if (ok && opt) bits(dv[ai], 6 * dv[ai] - 2, 9 * dv[ai] + 4);
      else bits(dv[ai], 13, 22);
   endtask
   task automatic give_verdict;
      $display("Compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Watchdog against a hung handshake.
   initial begin
      repeat (110000) @(posedge clock);
      failures++;
      give_verdict;
   end
   // Main sequence.
   initial begin
      logic [31:0] r;
      rst_b = 1'b0;
      osc_ext_sel = 1'b0;
      program_mode_select = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (20) @(posedge clock);
      chk_eq({31'h0, transceiver_power_down}, 32'h0);
      rst_b <= 1'b1;
      rd_chk(32'h4, 32'h3001F, 32'h20006);
      rd_chk(32'h0, 32'hFFFFFFFF, 32'h3);
      rd_chk(32'h40, 32'hFFFFFFFF, 32'h0);
      bus(1'b1, 32'h4, 32'hFFFFFFFF, r);
      rd_chk(32'h4, 32'h3001F, 32'h20006);
      u_far.hold_tx(1'b0, 400);
      u_far.hold_tx(1'b1, 400);
      chk_rng(n_pulse, 1, 1);
      chk_rng(pulse_w, 268, 330);
      bus(1'b1, 32'h0, 32'h2, r);
      u_far.hold_tx(1'b0, 400);
      u_far.hold_tx(1'b1, 400);
      chk_rng(n_pulse, 1, 1);
      bus(1'b1, 32'h0, 32'h3, r);
      osc_ext_sel <= 1'b1;
      round(4'h0, 1'b0);
      round(4'hC, 1'b1);
      round(4'hD, 1'b1);
      repeat (2) begin
         seed = lfsr(seed);
         round(4'(seed % 13), seed[15]);
      end
      give_verdict;
   end
endmodule // sir_pulse_shaper_endec_test
